// ### verilog/bsau_pkg.sv
// bsau_pkg.sv: constants, operation codes and bcd helpers of the arithmetic unit
// assumes: compiled before every bsau module that imports it
`default_nettype none

package bsau_pkg;

   // ==========================================================
   // widths and sizes
   localparam int BSAU_WORD = 32;
   localparam int BSAU_DIGITS = 8;
   localparam int BSAU_NIB = 4;
   localparam int BSAU_HALF = 16;
   localparam int BSAU_FMT_MAX = 16;
   localparam int BSAU_CNT_W = 5;
   localparam int BSAU_STACK_DEPTH = 8;

   // ==========================================================
   // values
   localparam logic [31:0] BSAU_WORD_RST = 32'h00000000;
   localparam logic [31:0] BSAU_RADIX = 32'h0000000A;
   localparam logic [31:0] BSAU_BCD_MOD = 32'h05F5E100; // ten to the eighth
   localparam logic [31:0] BSAU_DIV4_MAX = 32'h0000270F; // largest four-digit divisor
   localparam logic [31:0] BSAU_DIV_SAFE = 32'h00000001;
   localparam logic [4:0] BSAU_DIGIT_MAX = 5'h09;
   localparam logic [4:0] BSAU_DIGIT_ADJ = 5'h06;
   localparam logic [15:0] BSAU_HALF_ZERO = 16'h0000;

   // ==========================================================
   // operation codes
   typedef enum logic [2:0] {
      BIT_RANGE_BCD_MULTIPLY,
      BIT_RANGE_BCD_DIVIDE,
      BCD_STACK_ADD,
      BCD_STACK_SUBTRACT,
      BCD_STACK_MULTIPLY,
      BCD_STACK_DIVIDE,
      BINARY_STACK_ADD
   } bsau_op_t;

   // ==========================================================
   // helpers
   // packed bcd word to binary
   function automatic logic [31:0] bsau_bcd2bin(input logic [31:0] v);
      logic [31:0] r;
      r = BSAU_WORD_RST;
      for (int i = BSAU_DIGITS - 1; i >= 0; i--) begin
         r = 32'(r * BSAU_RADIX) + 32'(v[i*BSAU_NIB +: BSAU_NIB]);
      end
      return r;
   endfunction

   // binary below ten to the eighth to packed bcd
   function automatic logic [31:0] bsau_bin2bcd(input logic [31:0] v);
      logic [31:0] r;
      logic [31:0] t;
      r = BSAU_WORD_RST;
      t = v;
      for (int i = 0; i < BSAU_DIGITS; i++) begin
         r[i*BSAU_NIB +: BSAU_NIB] = 4'(t % BSAU_RADIX);
         t = t / BSAU_RADIX;
      end
      return r;
   endfunction

   // every nibble a legal decimal digit
   function automatic logic bsau_is_bcd(input logic [31:0] v);
      logic ok;
      ok = 1'b1;
      for (int i = 0; i < BSAU_DIGITS; i++) begin
         if (5'(v[i*BSAU_NIB +: BSAU_NIB]) > BSAU_DIGIT_MAX) begin
            ok = 1'b0;
         end
      end
      return ok;
   endfunction

endpackage

`default_nettype wire

// ### verilog/bsau_bcd_adder.sv
// bsau_bcd_adder.sv: combinational packed bcd adder and ten's complement subtractor
// assumes: operands are legal bcd; illegal digits give an unspecified sum
`timescale 1ns/10ps
`default_nettype none

module bsau_bcd_adder #(
   parameter int DIGITS = bsau_pkg::BSAU_DIGITS
) (
   input wire logic [DIGITS*bsau_pkg::BSAU_NIB-1:0] addendA,
   input wire logic [DIGITS*bsau_pkg::BSAU_NIB-1:0] addendB,
   input wire logic subtract,
   output logic [DIGITS*bsau_pkg::BSAU_NIB-1:0] sum,
   output logic carryLow,
   output logic carryHigh
);
   import bsau_pkg::*;

   // ==========================================================
   // digit ripple; subtract adds the nines complement plus one
   always_comb begin
      logic [4:0] d;
      logic [4:0] b;
      logic c;
      d = 5'h00;
      b = 5'h00;
      c = subtract;
      sum = '0;
      carryLow = 1'b0;
      for (int i = 0; i < DIGITS; i++) begin
         b = 5'(addendB[i*BSAU_NIB +: BSAU_NIB]);
         if (subtract) begin
            b = 5'(BSAU_DIGIT_MAX - b);
         end
         d = 5'(5'(addendA[i*BSAU_NIB +: BSAU_NIB]) + b + 5'(c));
         c = (d > BSAU_DIGIT_MAX); // decimal carry out of this digit
         if (c) begin
            d = 5'(d + BSAU_DIGIT_ADJ);
         end
         sum[i*BSAU_NIB +: BSAU_NIB] = d[3:0];
         if (i == DIGITS / 2 - 1) begin
            carryLow = c; // carry out of the low half
         end
      end
      carryHigh = c;
   end

endmodule

`default_nettype wire

// ### verilog/bsau_top.sv
// bsau_top.sv: accumulator, accumulator stack and arithmetic of the controller cpu
// assumes: a sequencer on clk gives one-cycle start pulses with op and operands
`timescale 1ns/10ps
`default_nettype none

// What this block does
// - bit-range multiply: low four acc digits times bit-range bcd value into acc
// - bit-range divide: acc over bit-range value, quotient acc, remainder stack top
// - bcd stack add: acc plus stack top as eight-digit bcd into acc
// - bcd stack subtract: acc minus stack top as eight-digit bcd into acc
// - bcd stack multiply: four-digit stack top times four-digit acc into acc
// - bcd stack divide: eight-digit acc over four-digit top, remainder replaces top
// - binary stack add: acc plus stack top as 32-bit binary into acc
// - stack add, subtract and multiply drop the top and move entries up
// - loading the acc pushes its old value onto the stack top
// - zero flag follows whether the acc result is zero
// - negative flag set when the acc result is negative
// - invalid-bcd flag set when a bcd operand holds an illegal digit
// - divides set range error when the divisor cannot be handled
// - adds set short carry on carry out of the low half
// - adds set long carry on carry out of the full word
// - subtract sets short borrow on borrow out of the low half
// - subtract sets long borrow on borrow out of the full word
// - binary add sets overflow when the signed sum sign is wrong
module bsau_top #(
   parameter int STACK_DEPTH = bsau_pkg::BSAU_STACK_DEPTH
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic start,
   input wire bsau_pkg::bsau_op_t op,
   input wire logic [bsau_pkg::BSAU_FMT_MAX-1:0] fmtBits,
   input wire logic [bsau_pkg::BSAU_CNT_W-1:0] fmtCount,
   input wire logic loadStb,
   input wire logic [bsau_pkg::BSAU_WORD-1:0] loadData,
   output logic [bsau_pkg::BSAU_WORD-1:0] accOut,
   output logic [bsau_pkg::BSAU_WORD-1:0] stackTop,
   output logic done,
   output logic zeroResultFlag,
   output logic negativeResultFlag,
   output logic invalidBcdFlag,
   output logic operandRangeErrorFlag,
   output logic shortCarryFlag,
   output logic longCarryFlag,
   output logic shortBorrowFlag,
   output logic longBorrowFlag,
   output logic signedOverflowFlag
);
   import bsau_pkg::*;

   // ==========================================================
   // state
   logic [31:0] acc_ff;
   logic [31:0] stack_ff [STACK_DEPTH];
   logic done_ff, zero_ff, negative_ff, invalidBcd_ff, rangeError_ff;
   logic shortCarry_ff, longCarry_ff, shortBorrow_ff, longBorrow_ff, overflow_ff;

   // ==========================================================
   // operand preparation
   logic [15:0] fmtMask;
   logic [31:0] fmtOperand, accLow, topLow, accBin, topBin, fmtBin, accLowBin, topLowBin;

   // bit-range operand: bit 0 is lsb, bits at or above count are zero
   always_comb begin
      fmtMask = BSAU_HALF_ZERO;
      for (int i = 0; i < BSAU_FMT_MAX; i++) begin
         if (5'(i) < fmtCount) begin
            fmtMask[i] = 1'b1;
         end
      end
   end

   assign fmtOperand = {BSAU_HALF_ZERO, fmtBits & fmtMask};
   assign accLow = {BSAU_HALF_ZERO, acc_ff[BSAU_HALF-1:0]};
   assign topLow = {BSAU_HALF_ZERO, stack_ff[0][BSAU_HALF-1:0]};

   // decimal operands in binary for multiply and divide
   assign accBin = bsau_bcd2bin(acc_ff);
   assign topBin = bsau_bcd2bin(stack_ff[0]);
   assign fmtBin = bsau_bcd2bin(fmtOperand);
   assign accLowBin = bsau_bcd2bin(accLow);
   assign topLowBin = bsau_bcd2bin(topLow);

   // ==========================================================
   // arithmetic
   logic [31:0] bcdSum, mulFmtRes, mulStackRes, divisorBin, divSafe, quotBcd, remBcd;
   logic bcdCarryLow, bcdCarryHigh, isSubtract, binCarryLow, binOverflow, divRangeErr;
   logic [32:0] binSum;

   assign isSubtract = (op == BCD_STACK_SUBTRACT);

   // shared decimal adder, ten's complement when subtracting
   bsau_bcd_adder #(
      .DIGITS(BSAU_DIGITS)
   ) u_adder (
      .addendA(acc_ff),
      .addendB(stack_ff[0]),
      .subtract(isSubtract),
      .sum(bcdSum),
      .carryLow(bcdCarryLow),
      .carryHigh(bcdCarryHigh)
   );

   // binary add with half-word carry and signed overflow
   assign binSum = {1'b0, acc_ff} + {1'b0, stack_ff[0]};
   assign binCarryLow = 1'((17'(acc_ff[15:0]) + 17'(stack_ff[0][15:0])) >> BSAU_HALF);
   assign binOverflow = (acc_ff[31] == stack_ff[0][31]) && (binSum[31] != acc_ff[31]);

   // four-digit products fit in eight digits
   assign mulFmtRes = bsau_bin2bcd(32'(accLowBin * fmtBin));
   assign mulStackRes = bsau_bin2bcd(32'(accLowBin * topLowBin));

   // divisor must be nonzero and four digits at most
   assign divisorBin = (op == BIT_RANGE_BCD_DIVIDE) ? fmtBin : topBin;
   assign divRangeErr = (divisorBin == BSAU_WORD_RST) || (divisorBin > BSAU_DIV4_MAX);
   assign divSafe = divRangeErr ? BSAU_DIV_SAFE : divisorBin;
   assign quotBcd = bsau_bin2bcd(accBin / divSafe);
   assign remBcd = bsau_bin2bcd(accBin % divSafe);

   // ==========================================================
   // operation decode
   logic [31:0] nxt_acc, nxt_rem;
   logic popStack, writeRem, nxt_negative, nxt_invalidBcd, wrBcd, wrRange;
   logic wrCarry, wrBorrow, wrOverflow, nxt_shortCarry, nxt_longCarry;

   // result, stack action and which flags this op owns
   always_comb begin
      nxt_acc = acc_ff;
      nxt_rem = remBcd;
      popStack = 1'b0;
      writeRem = 1'b0;
      nxt_negative = 1'b0;
      nxt_invalidBcd = 1'b0;
      wrBcd = 1'b1;
      wrRange = 1'b0;
      wrCarry = 1'b0;
      wrBorrow = 1'b0;
      wrOverflow = 1'b0;
      nxt_shortCarry = bcdCarryLow;
      nxt_longCarry = bcdCarryHigh;
      case (op)
         BIT_RANGE_BCD_MULTIPLY: begin
            nxt_acc = mulFmtRes;
            nxt_invalidBcd = !bsau_is_bcd(accLow) || !bsau_is_bcd(fmtOperand);
         end
         BIT_RANGE_BCD_DIVIDE: begin
            wrRange = 1'b1;
            if (!divRangeErr) begin
               nxt_acc = quotBcd;
               writeRem = 1'b1;
            end
            nxt_invalidBcd = !bsau_is_bcd(acc_ff) || !bsau_is_bcd(fmtOperand);
         end
         BCD_STACK_ADD: begin
            nxt_acc = bcdSum;
            popStack = 1'b1;
            wrCarry = 1'b1;
            nxt_invalidBcd = !bsau_is_bcd(acc_ff) || !bsau_is_bcd(stack_ff[0]);
         end
         BCD_STACK_SUBTRACT: begin
            nxt_acc = bcdSum;
            popStack = 1'b1;
            wrBorrow = 1'b1;
            nxt_negative = !bcdCarryHigh;
            nxt_invalidBcd = !bsau_is_bcd(acc_ff) || !bsau_is_bcd(stack_ff[0]);
         end
         BCD_STACK_MULTIPLY: begin
            nxt_acc = mulStackRes;
            popStack = 1'b1;
            nxt_invalidBcd = !bsau_is_bcd(accLow) || !bsau_is_bcd(topLow);
         end
         BCD_STACK_DIVIDE: begin
            wrRange = 1'b1;
            if (!divRangeErr) begin
               nxt_acc = quotBcd;
               writeRem = 1'b1;
            end
            nxt_invalidBcd = !bsau_is_bcd(acc_ff) || !bsau_is_bcd(stack_ff[0]);
         end
         BINARY_STACK_ADD: begin
            nxt_acc = binSum[31:0];
            popStack = 1'b1;
            wrBcd = 1'b0;
            wrCarry = 1'b1;
            wrOverflow = 1'b1;
            nxt_shortCarry = binCarryLow;
            nxt_longCarry = binSum[32];
            nxt_negative = binSum[31];
         end
         default: begin
            wrBcd = 1'b0;
         end
      endcase
   end

   // ==========================================================
   // accumulator: op result wins over a load in the same cycle
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         acc_ff <= BSAU_WORD_RST;
      end else if (start) begin
         acc_ff <= nxt_acc;
      end else if (loadStb) begin
         acc_ff <= loadData;
      end
   end

   // stack: pop after arithmetic, remainder to top, push on load
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < STACK_DEPTH; i++) begin
            stack_ff[i] <= BSAU_WORD_RST;
         end
      end else if (start) begin
         if (popStack) begin
            for (int i = 0; i < STACK_DEPTH - 1; i++) begin
               stack_ff[i] <= stack_ff[i+1];
            end
            stack_ff[STACK_DEPTH-1] <= BSAU_WORD_RST;
         end else if (writeRem) begin
            stack_ff[0] <= nxt_rem;
         end
      end else if (loadStb) begin
         stack_ff[0] <= acc_ff;
         for (int i = 1; i < STACK_DEPTH; i++) begin
            stack_ff[i] <= stack_ff[i-1];
         end
      end
   end

   // completion pulse one cycle after start
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         done_ff <= 1'b0;
      end else begin
         done_ff <= start;
      end
   end

   // zero and negative flags, written by every op
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         zero_ff <= 1'b0;
         negative_ff <= 1'b0;
      end else if (start) begin
         zero_ff <= (nxt_acc == BSAU_WORD_RST);
         negative_ff <= nxt_negative;
      end
   end

   // invalid digit and divisor range flags, held when not owned
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         invalidBcd_ff <= 1'b0;
         rangeError_ff <= 1'b0;
      end else if (start) begin
         if (wrBcd) begin
            invalidBcd_ff <= nxt_invalidBcd;
         end
         if (wrRange) begin
            rangeError_ff <= divRangeErr;
         end
      end
   end

   // carry, borrow and overflow flags, held when not owned
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         shortCarry_ff <= 1'b0;
         longCarry_ff <= 1'b0;
         shortBorrow_ff <= 1'b0;
         longBorrow_ff <= 1'b0;
         overflow_ff <= 1'b0;
      end else if (start) begin
         if (wrCarry) begin
            shortCarry_ff <= nxt_shortCarry;
            longCarry_ff <= nxt_longCarry;
         end
         if (wrBorrow) begin
            shortBorrow_ff <= !bcdCarryLow;
            longBorrow_ff <= !bcdCarryHigh;
         end
         if (wrOverflow) begin
            overflow_ff <= binOverflow;
         end
      end
   end

   // ==========================================================
   // outputs
   assign accOut = acc_ff;
   assign stackTop = stack_ff[0];
   assign done = done_ff;
   assign zeroResultFlag = zero_ff;
   assign negativeResultFlag = negative_ff;
   assign invalidBcdFlag = invalidBcd_ff;
   assign operandRangeErrorFlag = rangeError_ff;
   assign shortCarryFlag = shortCarry_ff;
   assign longCarryFlag = longCarry_ff;
   assign shortBorrowFlag = shortBorrow_ff;
   assign longBorrowFlag = longBorrow_ff;
   assign signedOverflowFlag = overflow_ff;

   // ==========================================================
   // checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   logic [31:0] accOutBin;
   logic [31:0] topOutBin;
   assign accOutBin = bsau_bcd2bin(acc_ff);
   assign topOutBin = bsau_bcd2bin(stack_ff[0]);

   zero_flag_a: assert property (done_ff |-> (zero_ff == (acc_ff == BSAU_WORD_RST)))
      else $error("zero flag disagrees with accumulator");

   load_push_a: assert property (loadStb && !start |=> stack_ff[0] == $past(acc_ff)
      && acc_ff == $past(loadData))
      else $error("load did not push the old accumulator");

   stack_pop_a: assert property (start && popStack |=> stack_ff[0] == $past(stack_ff[1]))
      else $error("stack did not move up after op");

   bin_add_a: assert property (start && op == BINARY_STACK_ADD
      |=> acc_ff == 32'($past(acc_ff) + $past(stack_ff[0])))
      else $error("binary add result wrong");

   bcd_add_a: assert property (start && op == BCD_STACK_ADD && !nxt_invalidBcd
      |=> accOutBin == ($past(accBin) + $past(topBin)) % BSAU_BCD_MOD)
      else $error("bcd add result wrong");

   div_remain_a: assert property (start && op == BCD_STACK_DIVIDE && !divRangeErr
      && !nxt_invalidBcd
      |=> 32'(accOutBin * $past(divisorBin)) + topOutBin == $past(accBin))
      else $error("divide quotient and remainder inconsistent");

   range_hold_a: assert property (start && wrRange && divRangeErr
      |=> rangeError_ff && $stable(acc_ff) && $stable(stack_ff[0]))
      else $error("bad divisor not flagged or acc changed");

   overflow_flag_a: assert property (start && op == BINARY_STACK_ADD
      |=> overflow_ff == ($past(acc_ff[31]) == $past(stack_ff[0][31])
      && acc_ff[31] != $past(acc_ff[31])))
      else $error("signed overflow flag wrong");

   carry_hold_a: assert property (start && op != BCD_STACK_ADD && op != BINARY_STACK_ADD
      |=> $stable(shortCarry_ff) && $stable(longCarry_ff))
      else $error("carry flags changed by an op that does not own them");

endmodule

`default_nettype wire

// ### tb/bsau_seq_model.sv
// bsau_seq_model.sv: instruction sequencer model that feeds the arithmetic unit
// assumes: clk shared with the unit, inputs changed on the falling edge
`timescale 1ns/10ps
`default_nettype none

module bsau_seq_model (
   input wire logic clk,
   input wire logic done,
   output logic start,
   output bsau_pkg::bsau_op_t op,
   output logic [15:0] fmtBits,
   output logic [4:0] fmtCount,
   output logic loadStb,
   output logic [31:0] loadData
);
   import bsau_pkg::*;

   // ==========================================================
   // idle values at time zero
   initial begin
      start = 1'b0;
      op = BCD_STACK_ADD;
      fmtBits = 16'h0000;
      fmtCount = 5'h00;
      loadStb = 1'b0;
      loadData = 32'h00000000;
   end

   // one load pulse, data scrambled once released
   task automatic doLoad(input logic [31:0] d);
      @(negedge clk);
      loadStb = 1'b1;
      loadData = d;
      @(negedge clk);
      loadStb = 1'b0;
      loadData = ~d;
   endtask

   // one start pulse; done must be seen in the following cycle
   task automatic doOp(input bsau_op_t o, input logic [15:0] b, input logic [4:0] n,
                       output logic ok);
      @(negedge clk);
      start = 1'b1;
      op = o;
      fmtBits = b;
      fmtCount = n;
      @(negedge clk);
      start = 1'b0;
      fmtBits = ~b;
      ok = (done === 1'b1); // flags read now, before any later op
   endtask
endmodule

`default_nettype wire

// ### tb/bsau_top_test.sv
// bsau_top_test.sv: self-checking bench of the arithmetic unit
// assumes: bsau_pkg, bsau_top and bsau_seq_model compiled before it
`timescale 1ns/10ps
`default_nettype none

module bsau_top_test;
   import bsau_pkg::*;

   // ==========================================================
   // signals
   logic clk = 1'b0;
   logic rst = 1'b1;
   wire logic start, loadStb, done;
   wire bsau_op_t op;
   wire logic [15:0] fmtBits;
   wire logic [4:0] fmtCount;
   wire logic [31:0] loadData, accOut, stackTop;
   wire logic zf, nf, inf, rf, scf, lcf, sbf, lbf, vf;
   wire logic [8:0] flagVec = {zf, nf, inf, rf, scf, lcf, sbf, lbf, vf};
   int failCount = 0;
   int totalChecks = 0;
   int testNum = 0;

   // 10 MHz clock
   always #50 clk = ~clk;

   // ==========================================================
   // design and sequencer
   bsau_top dut (.clk(clk), .rst(rst), .start(start), .op(op), .fmtBits(fmtBits),
      .fmtCount(fmtCount), .loadStb(loadStb), .loadData(loadData), .accOut(accOut),
      .stackTop(stackTop), .done(done), .zeroResultFlag(zf), .negativeResultFlag(nf),
      .invalidBcdFlag(inf), .operandRangeErrorFlag(rf), .shortCarryFlag(scf),
      .longCarryFlag(lcf), .shortBorrowFlag(sbf), .longBorrowFlag(lbf),
      .signedOverflowFlag(vf));

   bsau_seq_model seq (.clk(clk), .done(done), .start(start), .op(op), .fmtBits(fmtBits),
      .fmtCount(fmtCount), .loadStb(loadStb), .loadData(loadData));

   // ==========================================================
   // checking and closing
   task automatic chk(input logic [31:0] exp, input logic [31:0] got);
      totalChecks++;
      if (got !== exp) begin
         failCount++;
         $display("CHECK FAILED t=%0t exp=%h got=%h", $time, exp, got);
      end
   endtask

   task automatic endOfTest;
      $display("checks %0d mismatches %0d", totalChecks, failCount);
      if (failCount == 0 && totalChecks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // marker, top and acc loaded, then one op; owned flags compared under mask
   task automatic run(input bsau_op_t o, input logic [31:0] tv, input logic [31:0] av,
                      input logic [15:0] b, input logic [4:0] n, input logic [31:0] ea,
                      input logic [31:0] et, input logic [8:0] ef, input logic [8:0] m);
      logic ok;
      seq.doLoad(32'h00000077);
      seq.doLoad(tv);
      seq.doLoad(av);
      chk(av, accOut);
      chk(tv, stackTop);
      seq.doOp(o, b, n, ok);
      chk({31'h0, ok}, 32'h00000001);
      chk(ea, accOut);
      chk(et, stackTop);
      chk({23'h0, ef & m}, {23'h0, flagVec & m});
      testNum++;
      $display("test %0d done", testNum);
   endtask

   // ==========================================================
   // hang guard
   initial begin
      repeat (5000) @(posedge clk);
      failCount++;
      endOfTest();
   end

   // main sequence
   initial begin
      repeat (20) @(negedge clk);
      rst = 1'b0;
      chk(32'h00000000, accOut);
      chk(32'h00000000, stackTop);
      chk(32'h00000000, {22'h0, done, flagVec});
      run(BCD_STACK_ADD, 32'h30, 32'h12, 16'h0, 5'h0, 32'h42, 32'h77, 9'h000, 9'h1D8);
      run(BCD_STACK_ADD, 32'h9999, 32'h1, 16'h0, 5'h0, 32'h10000, 32'h77, 9'h010, 9'h1D8);
      run(BCD_STACK_ADD, 32'h99999999, 32'h1, 16'h0, 5'h0, 32'h0, 32'h77, 9'h118, 9'h1D8);
      run(BCD_STACK_ADD, 32'h1, 32'hA, 16'h0, 5'h0, 32'h11, 32'h77, 9'h040, 9'h040);
      run(BCD_STACK_SUBTRACT, 32'h5, 32'h3, 16'h0, 5'h0, 32'h99999998, 32'h77, 9'h086,
          9'h1C6);
      run(BCD_STACK_SUBTRACT, 32'h1, 32'h10000, 16'h0, 5'h0, 32'h9999, 32'h77, 9'h004,
          9'h1C6);
      run(BCD_STACK_MULTIPLY, 32'h1234, 32'h5, 16'h0, 5'h0, 32'h6170, 32'h77, 9'h000,
          9'h1C0);
      run(BCD_STACK_DIVIDE, 32'h100, 32'h12345, 16'h0, 5'h0, 32'h123, 32'h45, 9'h000,
          9'h1E0);
      run(BCD_STACK_DIVIDE, 32'h0, 32'h12345, 16'h0, 5'h0, 32'h12345, 32'h0, 9'h020,
          9'h1E0);
      run(BINARY_STACK_ADD, 32'h7FFFFFFF, 32'h1, 16'h0, 5'h0, 32'h80000000, 32'h77, 9'h091,
          9'h199);
      run(BINARY_STACK_ADD, 32'hFFFFFFFF, 32'h1, 16'h0, 5'h0, 32'h0, 32'h77, 9'h118,
          9'h199);
      run(BIT_RANGE_BCD_MULTIPLY, 32'h55, 32'h12, 16'hFF03, 5'h04, 32'h36, 32'h55, 9'h000,
          9'h1C0);
      run(BIT_RANGE_BCD_MULTIPLY, 32'h55, 32'h12, 16'hFFFF, 5'h00, 32'h0, 32'h55, 9'h100,
          9'h1C0);
      run(BIT_RANGE_BCD_DIVIDE, 32'h55, 32'h100, 16'hFFF7, 5'h03, 32'h14, 32'h2, 9'h000,
          9'h1E0);
      run(BIT_RANGE_BCD_DIVIDE, 32'h55, 32'h12345, 16'h1000, 5'h10, 32'h12, 32'h345, 9'h000,
          9'h1E0);
      endOfTest();
   end
endmodule

`default_nettype wire
